// File: adcsr_top.sv
// adcsr_top: serial register decoder of the converter
// assumes sclk, csN and din are pins asynchronous to clk, with
// sclk much slower than clk so every edge is seen
`timescale 1ns/1ps
module adcsr_top
    import adcsr_pkg::*;
(
    // clock and reset
    input  wire logic           clk,
    input  wire logic           sys_rst,
    // serial port
    input  wire logic           sclk,
    input  wire logic           csN,
    input  wire logic           din,
    // conversion engine
    input  wire logic           convStart,
    output adcsr_conv_type      convSetup,
    output adcsr_ctl_type       ctlOut,
    output logic      [7:0]     rangeOut,
    output logic      [3:0]     seqOut,
    output adcsr_pwr_type       powerState,
    output logic                frameDone
);
    // ============================================================
    // pin synchronisers
    logic sclkS;
    logic csNS;
    logic dinS;

    adcsr_sync uSyncClk (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .resetVal (1'b0),
        .din      (sclk),
        .dout     (sclkS)
    );
    adcsr_sync uSyncCs (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .resetVal (1'b1),
        .din      (csN),
        .dout     (csNS)
    );
    adcsr_sync uSyncDin (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .resetVal (1'b0),
        .din      (din),
        .dout     (dinS)
    );

    // ============================================================
    // edge detection on synchronised serial clock
    logic sclkPrev_r;
    logic sclkFall;
    logic sclkRise;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sclkPrev_r <= 1'b0;
        end else begin
            sclkPrev_r <= sclkS;
        end
    end
    // data is taken on the falling edge of the serial clock
    assign sclkFall = sclkPrev_r & ~sclkS & ~csNS;
    assign sclkRise = ~sclkPrev_r & sclkS & ~csNS;

    // ============================================================
    // shift register and bit counter
    logic [15:0] shift_r;
    logic [15:0] shift_nxt;
    logic [4:0]  bitCnt_r;
    logic [4:0]  riseCnt_r;
    logic        lastBit;

    assign shift_nxt = {shift_r[14:0], dinS};
    assign lastBit   = sclkFall && (bitCnt_r == 5'(FRAME_BITS - 1));

    always_ff @(posedge clk) begin
        if (sys_rst || csNS) begin
            bitCnt_r <= 5'h00;
        end else if (sclkFall) begin
            bitCnt_r <= lastBit ? 5'h00 : bitCnt_r + 5'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shift_r <= 16'h0000;
        end else if (sclkFall) begin
            shift_r <= shift_nxt;
        end
    end

    // rising edges since the last control update, for auto power modes
    logic ctlWritten_r;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            riseCnt_r <= 5'h00;
        end else if (ctlWritten_r) begin
            riseCnt_r <= 5'h00;
        end else if (sclkRise && riseCnt_r != 5'(AUTO_PM_EDGE)) begin
            riseCnt_r <= riseCnt_r + 5'h01;
        end
    end

    // ============================================================
    // header decode and register loads
    logic [2:0] header;
    logic       loadCtl;
    logic       loadRng;
    logic       loadSeq;

    assign header  = shift_nxt[15:13];

    // write flag 0 and the 1,1,0 code match nothing: no load
    always_comb begin
        loadCtl = 1'b0;
        loadRng = 1'b0;
        loadSeq = 1'b0;
        if (lastBit) begin
            case (header)
                HDR_CTL: loadCtl = 1'b1;
                HDR_RNG: loadRng = 1'b1;
                HDR_SEQ: loadSeq = 1'b1;
                default: ;
            endcase
        end
    end

    logic [11:0] ctlReg_r;
    logic [7:0]  rngReg_r;
    logic [3:0]  seqReg_r;

    // no read path exists: registers only feed the engine
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctlReg_r <= CTL_RESET;
        end else if (loadCtl) begin
            ctlReg_r <= shift_nxt[12:1];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rngReg_r <= RNG_RESET;
        end else if (loadRng) begin
            rngReg_r <= shift_nxt[12:5];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            seqReg_r <= SEQ_RESET;
        end else if (loadSeq) begin
            seqReg_r <= shift_nxt[12:9];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctlWritten_r <= 1'b0;
        end else begin
            ctlWritten_r <= loadCtl;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            frameDone <= 1'b0;
        end else begin
            frameDone <= lastBit;
        end
    end

    // ============================================================
    // control field split; reserved positions are simply dropped
    adcsr_ctl_type ctl;
    always_comb begin
        ctl.channelAddr  = ctlReg_r[CTL_ADDR_POS-1 +: 2];
        ctl.inputMode    = ctlReg_r[CTL_MODE_POS-1 +: 2];
        ctl.powerSel     = ctlReg_r[CTL_PM_POS-1 +: 2];
        ctl.coding       = ctlReg_r[CTL_CODING_POS-1];
        ctl.refSel       = ctlReg_r[CTL_REF_POS-1];
        ctl.sequencerCtl = ctlReg_r[CTL_SEQ_POS-1 +: 2];
    end
    assign ctlOut   = ctl;
    assign rangeOut = rngReg_r;
    assign seqOut   = seqReg_r;

    // ============================================================
    // sequencer: picks the channel of the next conversion
    logic [1:0] curChan_r;
    logic [1:0] nextChan;
    logic [1:0] listNext;
    logic       seqActive;
    logic [3:0] chanFlag;

    assign seqActive = (ctl.sequencerCtl == SQ_LISTED) ||
                       (ctl.sequencerCtl == SQ_CONSEC);

    // the sequence register keeps channel 0 in its top bit; chanFlag
    // turns it round so that chanFlag[n] belongs to channel n
    always_comb begin
        for (int n = 0; n < SEQ_WIDTH; n++) begin
            chanFlag[n] = seqReg_r[SEQ_WIDTH - 1 - n];
        end
    end

    // next flagged channel above curChan_r, wrapping to the lowest
    always_comb begin
        listNext = curChan_r;
        for (int i = 4; i >= 1; i--) begin
            if (chanFlag[2'(curChan_r + 2'(i))])
                listNext = 2'(curChan_r + 2'(i));
        end
    end

    always_comb begin
        case (ctl.sequencerCtl)
            SQ_LISTED: nextChan = listNext;
            SQ_CONSEC: nextChan = (curChan_r >= ctl.channelAddr) ?
                                  2'h0 : curChan_r + 2'h1;
            default:   nextChan = ctl.channelAddr;
        endcase
    end

    // a control write restarts the sequence at its first channel
    logic [1:0] firstChan;
    always_comb begin
        firstChan = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (chanFlag[i])
                firstChan = 2'(i);
        end
    end

    logic seqPending_r;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            seqPending_r <= 1'b0;
        end else if (ctlWritten_r) begin
            seqPending_r <= 1'b1;
        end else if (convStart) begin
            seqPending_r <= 1'b0;
        end
    end

    // a start in the cycle after a control load keeps the old channel
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            curChan_r <= 2'h0;
        end else if (convStart && !ctlWritten_r) begin
            if (!seqActive)
                curChan_r <= ctl.channelAddr;
            else if (seqPending_r)
                curChan_r <= (ctl.sequencerCtl == SQ_LISTED) ?
                             firstChan : 2'h0;
            else
                curChan_r <= nextChan;
        end
    end

    // ============================================================
    // setup latched at conversion start; an in-flight conversion
    // keeps its setup even if control is rewritten meanwhile
    logic [1:0] startChan;
    logic [2:0] plusSel;
    logic [2:0] minusSel;

    always_comb begin
        if (!seqActive)
            startChan = ctl.channelAddr;
        else if (seqPending_r)
            startChan = (ctl.sequencerCtl == SQ_LISTED) ? firstChan
                                                        : 2'h0;
        else
            startChan = nextChan;
    end

    adcsr_chan_sel uChanSel (
        .inputMode (ctl.inputMode),
        .channel   (startChan),
        .plusIn    (plusSel),
        .minusIn   (minusSel)
    );

    // range pair of the started channel, channel 0 in the top pair
    logic [1:0]     chanRange;
    adcsr_conv_type convSetup_nxt;

    assign chanRange = rngReg_r[RNG_WIDTH - 2 - 2*startChan +: 2];

    always_comb begin
        convSetup_nxt.valid       = 1'b1;
        convSetup_nxt.plusIn      = plusSel;
        convSetup_nxt.minusIn     = minusSel;
        convSetup_nxt.range       = chanRange;
        convSetup_nxt.coding      = ctl.coding;
        convSetup_nxt.refInternal = ctl.refSel;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            convSetup <= '0;
        end else if (convStart) begin
            convSetup <= convSetup_nxt;
        end
    end

    // ============================================================
    // power state
    // the edge count restarts one cycle after a control load; that
    // cycle still shows the old count and must not end the wait
    logic          autoDue;
    adcsr_pwr_type powerState_nxt;

    assign autoDue = !ctlWritten_r && riseCnt_r == 5'(AUTO_PM_EDGE);

    always_comb begin
        case (ctl.powerSel)
            PM_FULLSHUT: powerState_nxt = ADCSR_PWR_DOWN;
            PM_AUTOSHUT: powerState_nxt = autoDue ? ADCSR_PWR_DOWN
                                                  : ADCSR_PWR_ON;
            PM_STANDBY:  powerState_nxt = autoDue ? ADCSR_PWR_STANDBY
                                                  : ADCSR_PWR_ON;
            default:     powerState_nxt = ADCSR_PWR_ON;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            powerState <= ADCSR_PWR_ON;
        end else begin
            powerState <= powerState_nxt;
        end
    end
endmodule

// File: adcsr_pkg.sv
// adcsr_pkg: constants and types of the serial register decoder
// assumes a single clk domain; serial pins are asynchronous to it

// ============================================================
// package
package adcsr_pkg;
    localparam int FRAME_BITS     = 16;
    localparam int AUTO_PM_EDGE   = 15;
    localparam int CTL_WIDTH      = 12;
    localparam int RNG_WIDTH      = 8;
    localparam int SEQ_WIDTH      = 4;
    localparam logic [11:0] CTL_RESET = 12'h000;
    localparam logic [7:0]  RNG_RESET = 8'h00;
    localparam logic [3:0]  SEQ_RESET = 4'h0;
    // control field positions inside the 12 payload bits
    localparam int CTL_ADDR_POS   = 10;
    localparam int CTL_MODE_POS   = 8;
    localparam int CTL_PM_POS     = 6;
    localparam int CTL_CODING_POS = 5;
    localparam int CTL_REF_POS    = 4;
    localparam int CTL_SEQ_POS    = 2;
    // header codes
    localparam logic [2:0] HDR_CTL = 3'h4;
    localparam logic [2:0] HDR_RNG = 3'h5;
    localparam logic [2:0] HDR_SEQ = 3'h7;
    localparam logic [1:0] PM_NORMAL   = 2'h0;
    localparam logic [1:0] PM_STANDBY  = 2'h1;
    localparam logic [1:0] PM_AUTOSHUT = 2'h2;
    localparam logic [1:0] PM_FULLSHUT = 2'h3;
    localparam logic [1:0] SQ_LISTED   = 2'h1;
    localparam logic [1:0] SQ_CONSEC   = 2'h2;
    localparam logic [1:0] CFG_SINGLE  = 2'h0;
    localparam logic [1:0] CFG_PSEUDO3 = 2'h3;
    // analog mux selections: 3'h4 stands for the ground return
    localparam logic [2:0] MUX_GROUND  = 3'h4;

    typedef struct packed {
        logic [1:0] channelAddr;
        logic [1:0] inputMode;
        logic [1:0] powerSel;
        logic       coding;
        logic       refSel;
        logic [1:0] sequencerCtl;
    } adcsr_ctl_type;

    typedef struct packed {
        logic       valid;
        logic [2:0] plusIn;
        logic [2:0] minusIn;
        logic [1:0] range;
        logic       coding;
        logic       refInternal;
    } adcsr_conv_type;

    typedef enum logic [1:0] {
        ADCSR_PWR_ON,
        ADCSR_PWR_STANDBY,
        ADCSR_PWR_DOWN
    } adcsr_pwr_type;
endpackage

// File: adcsr_sync.sv
// adcsr_sync: two flip-flop synchroniser for one level
// assumes din is asynchronous to clk
`timescale 1ns/1ps
module adcsr_sync
    import adcsr_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic resetVal,
    // level
    input  wire logic din,
    output logic      dout
);
    logic stage1_r;

    // reset to the pin's idle level, so no false edge follows reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage1_r <= resetVal;
            dout     <= resetVal;
        end else begin
            stage1_r <= din;
            dout     <= stage1_r;
        end
    end
endmodule

// File: adcsr_chan_sel.sv
// adcsr_chan_sel: maps mode and channel address to mux inputs
// assumes inputMode comes from the applied control word and channel from the sequencer's start choice
`timescale 1ns/1ps
module adcsr_chan_sel
    import adcsr_pkg::*;
(
    // selection
    input  wire logic [1:0] inputMode,
    input  wire logic [1:0] channel,
    // analog mux
    output logic      [2:0] plusIn,
    output logic      [2:0] minusIn
);
    always_comb begin
        plusIn  = {1'b0, channel};
        minusIn = MUX_GROUND;
        case (inputMode)
            CFG_SINGLE: begin
                plusIn  = {1'b0, channel};
                minusIn = MUX_GROUND;
            end
            CFG_PSEUDO3: begin
                // address 11 is not allowed here; host keeps it away
                plusIn  = {1'b0, channel};
                minusIn = 3'h3;
            end
            default: begin
                plusIn  = {1'b0, channel[1], 1'b0};
                minusIn = {1'b0, channel[1], 1'b1};
            end
        endcase
    end
endmodule

// File: adcsr_host_model.sv
// adcsr_host_model: host end of the serial port, sends 16-bit frames
// assumes the bench calls send() from its own process on clk
`timescale 1ns/1ps
module adcsr_host_model
    import adcsr_pkg::*;
(
    // clock
    input  wire logic clk,
    // serial port
    output logic      sclk,
    output logic      csN,
    output logic      din
);
    // ============================================================
    // idle: sclk rests low, frame deselected
    initial begin
        sclk = 1'b0;
        csN  = 1'b1;
        din  = 1'b0;
    end

    // four clk per sclk phase keeps every edge above the sync depth
    task automatic send(input logic [15:0] w);
        @(posedge clk) csN <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = FRAME_BITS - 1; i >= 0; i--) begin
            din  <= w[i];
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
            repeat (4) @(posedge clk);
        end
        // released line must not keep showing the last bit
        din <= ~w[0];
        csN <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
endmodule

// File: adcsr_top_asserts.sv
// adcsr_top_asserts: port checks of the serial register decoder
// assumes one clk domain with synchronous active-high sys_rst
`timescale 1ns/1ps
module adcsr_top_asserts
    import adcsr_pkg::*;
(
    // clock and reset
    input  wire logic           clk,
    input  wire logic           sys_rst,
    // serial port
    input  wire logic           sclk,
    input  wire logic           csN,
    input  wire logic           din,
    // conversion engine
    input  wire logic           convStart,
    input  wire adcsr_conv_type convSetup,
    input  wire adcsr_ctl_type  ctlOut,
    input  wire logic [7:0]     rangeOut,
    input  wire logic [3:0]     seqOut,
    input  wire adcsr_pwr_type  powerState,
    input  wire logic           frameDone
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic       seqOff;
    logic [2:0] chan;
    logic [2:0] pairLo;
    logic [1:0] chanRange;
    assign seqOff    = ctlOut.sequencerCtl[1] == ctlOut.sequencerCtl[0];
    assign chan      = {1'b0, ctlOut.channelAddr};
    assign pairLo    = {1'b0, ctlOut.channelAddr[1], 1'b0};
    assign chanRange = 2'(rangeOut >> {~ctlOut.channelAddr, 1'b0});

    // ============================================================
    // registers
    reset_zero_a: assert property ($fell(sys_rst) |-> ctlOut == CTL_RESET
        && rangeOut == RNG_RESET && seqOut == SEQ_RESET)
        else $error("registers not zero after reset");
    ctl_load_a: assert property (!$stable(ctlOut) && !$past(sys_rst)
        |-> ##[0:1] frameDone) else $error("control changed outside frame");
    rng_load_a: assert property (!$stable(rangeOut) && !$past(sys_rst)
        |-> ##[0:1] frameDone) else $error("range changed outside frame");
    seq_load_a: assert property (!$stable(seqOut) && !$past(sys_rst)
        |-> ##[0:1] frameDone) else $error("sequence changed outside frame");
    done_pulse_a: assert property (frameDone |=> !frameDone)
        else $error("frame done longer than one cycle");
    // ============================================================
    // conversion setup
    setup_hold_a: assert property (!$past(convStart) && !$past(sys_rst)
        |-> $stable(convSetup)) else $error("setup moved without start");
    setup_attr_a: assert property (convStart |=> convSetup.valid
        && convSetup.coding == $past(ctlOut.coding)
        && convSetup.refInternal == $past(ctlOut.refSel))
        else $error("coding or reference not taken");
    single_map_a: assert property (convStart && seqOff
        && ctlOut.inputMode == CFG_SINGLE |=> convSetup.plusIn == $past(chan)
        && convSetup.minusIn == MUX_GROUND
        && convSetup.range == $past(chanRange))
        else $error("single-ended selection wrong");
    pseudo_map_a: assert property (convStart && seqOff
        && ctlOut.inputMode == CFG_PSEUDO3 |=> convSetup.plusIn == $past(chan)
        && convSetup.minusIn == 3'h3) else $error("pseudo selection wrong");
    pair_map_a: assert property (convStart && seqOff
        && ^ctlOut.inputMode |=> convSetup.plusIn == $past(pairLo)
        && convSetup.minusIn == ($past(pairLo) | 3'h1))
        else $error("pair selection wrong");
    pm_normal_a: assert property ((ctlOut.powerSel == PM_NORMAL) [*4]
        |-> powerState == ADCSR_PWR_ON) else $error("normal mode not on");

    cover property (convStart && !seqOff);
    cover property (powerState == ADCSR_PWR_DOWN);
    cover property (convStart && ctlOut.inputMode == CFG_PSEUDO3);
endmodule

bind adcsr_top adcsr_top_asserts chk (
    .clk(clk), .sys_rst(sys_rst), .sclk(sclk), .csN(csN), .din(din),
    .convStart(convStart), .convSetup(convSetup), .ctlOut(ctlOut),
    .rangeOut(rangeOut), .seqOut(seqOut), .powerState(powerState),
    .frameDone(frameDone)
);

// File: adcsr_tb.sv
// adcsr_tb: self-checking bench of the serial register decoder
// assumes the host model drives the serial pins, bench drives convStart
`timescale 1ns/1ps
module tb
    import adcsr_pkg::*;
;
    logic           clk = 1'b0;
    logic           sys_rst = 1'b1;
    logic           convStart = 1'b0;
    wire logic      sclk;
    wire logic      csN;
    wire logic      din;
    adcsr_conv_type convSetup;
    adcsr_ctl_type  ctlOut;
    logic [7:0]     rangeOut;
    logic [3:0]     seqOut;
    adcsr_pwr_type  powerState;
    logic           frameDone;
    int             numErrors = 0;
    int             samplesChecked = 0;
    int             doneCnt = 0;
    adcsr_ctl_type  ctlE = CTL_RESET[11:2];
    logic [7:0]     rngE = RNG_RESET;
    logic [3:0]     seqE = SEQ_RESET;

    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (frameDone === 1'b1) doneCnt <= doneCnt + 1;
    end

    adcsr_host_model host (.clk(clk), .sclk(sclk), .csN(csN), .din(din));
    adcsr_top dut (
        .clk(clk), .sys_rst(sys_rst), .sclk(sclk), .csN(csN), .din(din),
        .convStart(convStart), .convSetup(convSetup), .ctlOut(ctlOut),
        .rangeOut(rangeOut), .seqOut(seqOut), .powerState(powerState),
        .frameDone(frameDone)
    );

    // ============================================================
    // helpers
    task automatic chk(input string n, input logic [15:0] e, s);
        samplesChecked++;
        if (s !== e) begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    function automatic logic [15:0] ctlw(input logic [1:0] a, m, p,
                                         input logic c, r,
                                         input logic [1:0] s);
        return {HDR_CTL, 1'b0, a, m, p, c, r, s, 2'b00};
    endfunction

    task automatic frame(input logic [15:0] w);
        int n0;
        n0 = doneCnt;
        host.send(w);
        repeat (4) @(posedge clk);
        @(negedge clk);
        case (w[15:13])
            HDR_CTL: ctlE = adcsr_ctl_type'(w[11:2]);
            HDR_RNG: rngE = w[12:5];
            HDR_SEQ: seqE = w[12:9];
            default: ;
        endcase
        chk("frameDone", 16'h1, 16'(doneCnt != n0));
        chk("ctlOut", 16'(ctlE), 16'(ctlOut));
        chk("rangeOut", 16'(rngE), 16'(rangeOut));
        chk("seqOut", 16'(seqE), 16'(seqOut));
    endtask

    task automatic conv(input logic [2:0] p, mi, input logic c, r);
        @(posedge clk) convStart <= 1'b1;
        @(posedge clk) convStart <= 1'b0;
        @(negedge clk);
        chk("plusIn", 16'(p), 16'(convSetup.plusIn));
        chk("minusIn", 16'(mi), 16'(convSetup.minusIn));
        chk("coding", 16'(c), 16'(convSetup.coding));
        chk("refInternal", 16'(r), 16'(convSetup.refInternal));
    endtask

    // ============================================================
    // scenarios
    task automatic t_reset;
        chk("ctlOut", 16'(CTL_RESET), 16'(ctlOut));
        chk("rangeOut", 16'(RNG_RESET), 16'(rangeOut));
        chk("powerState", 16'(ADCSR_PWR_ON), 16'(powerState));
        $display("test reset done");
    endtask

    // ignored headers first, so a wrong load shows against zero
    task automatic t_headers;
        logic [2:0] ord [8] = '{3'h0, 3'h1, 3'h2, 3'h3,
                                3'h6, 3'h5, 3'h7, 3'h4};
        foreach (ord[i]) frame({ord[i], 13'h0b50});
        $display("test headers done");
    endtask

    task automatic t_power;
        adcsr_pwr_type e;
        for (int i = 0; i < 4; i++) begin
            frame(ctlw(2'h0, CFG_SINGLE, 2'(i), 1'b0, 1'b0, 2'h0));
            if (i == 1) chk("pwrEarly", 16'(ADCSR_PWR_ON), 16'(powerState));
            frame(16'h0000);
            e = i == 0 ? ADCSR_PWR_ON : i == 1 ? ADCSR_PWR_STANDBY
                                               : ADCSR_PWR_DOWN;
            chk("powerState", 16'(e), 16'(powerState));
        end
        $display("test power done");
    endtask

    task automatic t_convert;
        logic [2:0]     p;
        logic [2:0]     mi;
        adcsr_conv_type old;
        frame({HDR_RNG, 8'h1b, 5'h00});
        for (int m = 0; m < 4; m++) begin
            for (int a = 0; a < 4; a++) begin
                if (m == 3 && a == 3) continue;
                old = convSetup;
                frame(ctlw(2'(a), 2'(m), PM_NORMAL, a[0], a[1], 2'h0));
                chk("setupHeld", 16'(old), 16'(convSetup));
                p = (m == 1 || m == 2) ? {1'b0, a[1], 1'b0} : 3'(a);
                mi = m == 0 ? MUX_GROUND : m == 3 ? 3'h3 : p | 3'h1;
                conv(p, mi, a[0], a[1]);
                if (m == 0) chk("range", 16'(a), 16'(convSetup.range));
            end
        end
        $display("test convert done");
    endtask

    task automatic t_seq;
        logic [2:0] lst [4] = '{3'h1, 3'h3, 3'h1, 3'h3};
        frame({HDR_SEQ, 4'h5, 9'h000});
        frame(ctlw(2'h0, CFG_SINGLE, PM_NORMAL, 1'b1, 1'b1, SQ_LISTED));
        foreach (lst[i]) conv(lst[i], MUX_GROUND, 1'b1, 1'b1);
        frame(ctlw(2'h2, CFG_SINGLE, PM_NORMAL, 1'b0, 1'b0, SQ_CONSEC));
        for (int i = 0; i < 4; i++) conv(3'(i % 3), MUX_GROUND, 1'b0, 1'b0);
        // code 11 switches the sequencer off just like 00
        frame(ctlw(2'h1, CFG_SINGLE, PM_NORMAL, 1'b1, 1'b0, 2'h3));
        repeat (2) conv(3'h1, MUX_GROUND, 1'b1, 1'b0);
        $display("test sequencer done");
    endtask

    task automatic wrapUp;
        $display("checked %0d mismatches %0d", samplesChecked, numErrors);
        if (numErrors == 0 && samplesChecked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        t_reset;
        t_headers;
        t_power;
        t_convert;
        t_seq;
        wrapUp;
    end

    // about 35 frames of some 140 clk each; allow a wide margin
    initial begin
        repeat (30000) @(posedge clk);
        numErrors++;
        wrapUp;
    end
endmodule
